// >>> pkg/sram_cfg.svh
// constants for the edge-latched 4k x 1 static memory
`ifndef SRAM_CFG_SVH
`define SRAM_CFG_SVH
`define ROW_BITS 6
`define COL_BITS 6
`define ADDR_BITS 12
`define ROW_LSB 0
`define COL_LSB 6
`define CLK_PERIOD_NS 20
`define ACCESS_TIME_NS 200
`define PRESET_TIME_NS 100
`define ACCESS_CYCLES ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRESET_CYCLES ((`PRESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_BITS 8
`endif

// >>> pkg/sram_pkg.sv
// types for the edge-latched 4k x 1 static memory
package sram_pkg;
  typedef enum logic [3:0] {
    ph_idle_type_s = 4'h1,
    ph_access = 4'h2,
    ph_done = 4'h4,
    ph_preset = 4'h8
  } phase_type;
  typedef struct packed {
    logic [11:0] addr;
    logic sel;
  } latch_type;
  typedef struct packed {
    logic oe;
    logic output_block_high;
  } outctl_type;
endpackage

// >>> verilog/sram_sync.sv
// two-flop synchroniser for pin inputs
module sram_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule // sram_sync

// >>> verilog/sram_array.sv
// 4096 x 1 cell array, row/column addressed
`include "sram_cfg.svh"
module sram_array #(
  parameter int ROW_BITS = `ROW_BITS,
  parameter int COL_BITS = `COL_BITS
) (
  input wire logic clk_sys_in,
  input wire logic [ROW_BITS-1:0] row_in,
  input wire logic [COL_BITS-1:0] col_in,
  input wire logic wr_in,
  input wire logic wdata_in,
  output logic rdata_out
);
  logic cells_q [2**ROW_BITS][2**COL_BITS];
  always_ff @(posedge clk_sys_in)
  begin
    if (wr_in)
    begin
      cells_q[row_in][col_in] <= wdata_in;
    end
  end
  assign rdata_out = cells_q[row_in][col_in];
endmodule // sram_array

// >>> verilog/sram_core.sv
// edge-latched 4k x 1 static memory with status output
//
// How it works
// - 4096 one-bit cells addressed by a twelve-bit index.
// - low six bits pick the row, high six the column.
// - strobe rising edge starts a cycle and latches address and select.
// - address read only at the strobe rising edge, ignored after.
// - select is a separate pin latched with the address; deselected means no output, no write.
// - latched select holds until the next strobe rising edge.
// - write strobe does nothing while cycle strobe low; never gates output.
// - write only when selected, strobe high and write strobe low.
// - last stable input data before write end is what stays stored.
// - during a write the output shows the input data.
// - read data enters output register, stays while strobe high.
// - strobe fall starts preset; output held while strobe low.
// - output disabled while strobe low clears the output register.
// - strobe rising edge clears output latch and turns buffer off.
// - buffer on only when selected, enabled, not blocked, data ready.
// - host waits for preset done before a new cycle.
// - strobe may stay high or low for any time.
// - status output runs in every cycle, read or write.
// - status rises on valid data or at a strobe fall before it, falls after strobe low and preset.
// - status is two-state and ignores the output controls.
`include "sram_cfg.svh"
module sram_core #(
  parameter int ACCESS_CYCLES = `ACCESS_CYCLES,
  parameter int PRESET_CYCLES = `PRESET_CYCLES
) (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic cycle_strobe_in,
  input wire logic write_n_in,
  input wire logic chip_sel_in,
  input wire logic [`ADDR_BITS-1:0] cell_index_in,
  input wire logic data_in,
  input wire sram_pkg::outctl_type outctl_in,
  output logic data_out,
  output logic data_oe_out,
  output logic access_done_flag_out
);
  import sram_pkg::*;

  // all pins pass two flops before use
  localparam int SW = `ADDR_BITS + 6;
  logic [SW-1:0] raw;
  logic [SW-1:0] syn;
  assign raw = {cycle_strobe_in, write_n_in, chip_sel_in, cell_index_in, data_in,
    outctl_in.oe, outctl_in.output_block_high};

  sram_sync #(.WIDTH(SW)) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .pin_in(raw),
    .sync_out(syn)
  );

  logic ce;
  logic we_n;
  logic cs;
  logic [`ADDR_BITS-1:0] idx;
  logic din;
  logic oe;
  logic od;
  assign {ce, we_n, cs, idx, din, oe, od} = syn;

  logic ce_q;
  logic ce_rise;
  logic ce_fall;
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      ce_q <= 1'b0;
    end
    else
    begin
      ce_q <= ce;
    end
  end
  assign ce_rise = ce && !ce_q;
  assign ce_fall = !ce && ce_q;

  // address and select latch
  latch_type lat_q;
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      lat_q <= '0;
    end
    else if (ce_rise)
    begin
      lat_q <= '{addr: idx, sel: cs};
    end
  end

  // phase machine with access and preset counters
  phase_type ph_q;
  logic [`CNT_BITS-1:0] cnt_q;
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      ph_q <= ph_idle_type_s;
      cnt_q <= '0;
    end
    else
    begin
      unique case (ph_q)
        ph_idle_type_s:
        begin
          if (ce_rise)
          begin
            ph_q <= ph_access;
            cnt_q <= '0;
          end
        end
        ph_access:
        begin
          if (!ce)
          begin
            ph_q <= ph_preset;
            cnt_q <= '0;
          end
          else if (cnt_q >= `CNT_BITS'(ACCESS_CYCLES - 1))
          begin
            ph_q <= ph_done;
          end
          else
          begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ph_done:
        begin
          if (!ce)
          begin
            ph_q <= ph_preset;
            cnt_q <= '0;
          end
        end
        ph_preset:
        begin
          if (cnt_q >= `CNT_BITS'(PRESET_CYCLES - 1))
          begin
            ph_q <= ph_idle_type_s;
          end
          else
          begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // write path
  logic wr_en;
  logic rd_bit;
  logic acc_end;
  assign acc_end = ph_q == ph_access && cnt_q >= `CNT_BITS'(ACCESS_CYCLES - 1);
  assign wr_en = lat_q.sel && ce && !we_n && ph_q != ph_idle_type_s;

  sram_array u_array (
    .clk_sys_in(clk_sys_in),
    .row_in(lat_q.addr[`ROW_LSB +: `ROW_BITS]),
    .col_in(lat_q.addr[`COL_LSB +: `COL_BITS]),
    .wr_in(wr_en),
    .wdata_in(din),
    .rdata_out(rd_bit)
  );

  // output data register and availability
  logic dreg_q;
  logic avail_q;
  logic wrote_q;
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      dreg_q <= 1'b0;
      avail_q <= 1'b0;
      wrote_q <= 1'b0;
    end
    else if (ce_rise)
    begin
      dreg_q <= 1'b0;
      avail_q <= 1'b0;
      wrote_q <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_en)
      begin
        dreg_q <= din;
        wrote_q <= 1'b1;
        // a write still marks data valid at the end of the access time
        avail_q <= avail_q || acc_end || ph_q == ph_done;
      end
      else if (acc_end)
      begin
        dreg_q <= wrote_q ? dreg_q : rd_bit;
        avail_q <= 1'b1;
      end
    end
    else if (!oe || od)
    begin
      dreg_q <= 1'b0;
    end
  end

  // outputs from flops
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      data_out <= 1'b0;
      data_oe_out <= 1'b0;
    end
    else
    begin
      data_out <= dreg_q;
      data_oe_out <= lat_q.sel && oe && !od && avail_q && !ce_rise;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      access_done_flag_out <= 1'b0;
    end
    else
    begin
      access_done_flag_out <= ph_q == ph_done || ph_q == ph_preset;
    end
  end

  // checks
  sequence s_rise;
    ce_rise;
  endsequence
  a_sel_latched: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    s_rise |=> lat_q.sel == $past(cs))
    else $error("select not latched at strobe rise");
  a_sel_holds: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !ce_rise |=> $stable(lat_q))
    else $error("latched select changed without strobe rise");
  a_no_write_desel: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_en |-> lat_q.sel && ce && !we_n)
    else $error("write without select and strobes");
  a_buf_off_desel: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !lat_q.sel |=> !data_oe_out)
    else $error("buffer on while deselected");
  a_rise_clears: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    s_rise |=> !data_oe_out ##0 dreg_q == 1'b0)
    else $error("strobe rise did not clear output");
  a_od_clears: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !ce && !ce_rise && (od || !oe) |=> !dreg_q)
    else $error("disable with strobe low did not clear data");
  a_status_rise: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    s_rise ##1 ce ##ACCESS_CYCLES ce |=> access_done_flag_out)
    else $error("status not up after access time");
  a_status_fall: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    ce_fall && ph_q == ph_done |=> ##PRESET_CYCLES access_done_flag_out
    ##1 !access_done_flag_out)
    else $error("status fall not after preset count");
  a_write_echo: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_en && !ce_rise |=> dreg_q == $past(din))
    else $error("write data not echoed on output");
endmodule // sram_core

// >>> dv/sram_host.sv
// host controller model that sequences the memory strobes
module sram_host (
  input wire logic clk_sys_in,
  input wire logic flag_in,
  output logic strobe_out,
  output logic write_n_out,
  output logic sel_out,
  output logic [11:0] index_out,
  output logic data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    strobe_out = 1'h0;
    write_n_out = 1'h1;
    sel_out = 1'h0;
    index_out = 12'h000;
    data_out = 1'h0;
  end
  task automatic wait_flag(input logic lvl, output bit ok);
    int n;
    n = 0;
    while (flag_in !== lvl && n < 80)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    ok = n < 80;
  endtask
  task automatic start(input logic [11:0] a, input logic s, input logic w, input logic d);
    @(negedge clk_sys_in);
    index_out = a;
    sel_out = s;
    data_out = d;
    write_n_out = ~w;
    strobe_out = 1'h1;
  endtask
  task automatic finish_access(output bit ok);
    repeat (3) @(negedge clk_sys_in);
    index_out = ~index_out;
    sel_out = ~sel_out;
    wait_flag(1'h1, ok);
  endtask
  task automatic stop(output bit ok);
    repeat ($urandom % 4) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    strobe_out = 1'h0;
    write_n_out = 1'h1;
    wait_flag(1'h0, ok);
    // write strobe wiggles while the cycle strobe is low
    write_n_out = 1'h0;
    data_out = ~data_out;
  endtask
endmodule // sram_host

// >>> dv/tb_edge_latched_static_ram_4kx1.sv
// self-checking bench for the edge-latched 4k x 1 memory
module tb_edge_latched_static_ram_4kx1;
  import sram_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in;
  logic reset_n_in;
  logic strobe, write_n, sel, din, dout, doe, flag;
  logic [11:0] index;
  outctl_type outctl;
  bit mem [0:4095];
  logic [11:0] alist [16];
  int fail_count;
  int comparisons;
  sram_core #(.ACCESS_CYCLES(4), .PRESET_CYCLES(2)) sram_core_i (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .cycle_strobe_in(strobe),
    .write_n_in(write_n), .chip_sel_in(sel), .cell_index_in(index), .data_in(din),
    .outctl_in(outctl), .data_out(dout), .data_oe_out(doe), .access_done_flag_out(flag));
  sram_host sram_host_i (
    .clk_sys_in(clk_sys_in), .flag_in(flag), .strobe_out(strobe), .write_n_out(write_n),
    .sel_out(sel), .index_out(index), .data_out(din));
  task automatic check(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic complete_run();
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one full cycle; clr disables the output while the strobe is low
  task automatic cycle(input logic [11:0] a, input logic s, input logic w, input logic d,
    input bit clr);
    bit ok;
    logic on;
    logic exp;
    on = s & outctl.oe & ~outctl.output_block_high;
    exp = w ? d : mem[a];
    sram_host_i.start(a, s, w, d);
    repeat (4) @(negedge clk_sys_in);
    check(doe, 1'h0, "buffer on at start");
    sram_host_i.finish_access(ok);
    check(ok, 1'h1, "no status rise");
    check(doe, on, "buffer enable");
    if (on)
      check(dout, exp, "data out");
    if (s && w)
      mem[a] = d;
    sram_host_i.stop(ok);
    check(ok, 1'h1, "no status fall");
    if (on)
      check(dout, exp, "data not held");
    if (clr)
    begin
      outctl.oe = 1'h0;
      repeat (4) @(negedge clk_sys_in);
      check(dout | doe, 1'h0, "register not cleared");
      outctl.oe = 1'h1;
    end
  endtask
  initial
  begin
    clk_sys_in = 1'h0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    #200000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    complete_run();
  end
  initial
  begin
    fail_count = 0;
    comparisons = 0;
    reset_n_in = 1'h0;
    outctl = '{oe: 1'h1, output_block_high: 1'h0};
    void'($urandom(8));
    foreach (alist[i])
      alist[i] = i == 0 ? 12'h000 : i == 1 ? 12'hfff : 12'($urandom);
    repeat (6) @(negedge clk_sys_in);
    reset_n_in = 1'h1;
    repeat (8) @(negedge clk_sys_in);
    foreach (alist[i])
      cycle(alist[i], 1'h1, 1'h1, 1'($urandom), 1'h0);
    foreach (alist[i])
      cycle(alist[i], 1'h1, 1'h0, 1'h0, i == 3);
    foreach (alist[i])
      cycle(alist[i], 1'h0, 1'h1, ~mem[alist[i]], 1'h0);
    outctl.output_block_high = 1'h1;
    cycle(alist[2], 1'h1, 1'h0, 1'h0, 1'h0);
    outctl = '{oe: 1'h0, output_block_high: 1'h0};
    cycle(alist[4], 1'h1, 1'h0, 1'h0, 1'h0);
    outctl.oe = 1'h1;
    foreach (alist[i])
      cycle(alist[i], 1'h1, 1'h0, 1'h0, 1'h0);
    complete_run();
  end
endmodule // tb_edge_latched_static_ram_4kx1
